// ==== crt_htiming_defs.vh ====
`ifndef CRT_HTIMING_DEFS_VH
`define CRT_HTIMING_DEFS_VH

// ----------------------------------------------------------------------
// Host I/O port addresses.
// ----------------------------------------------------------------------
`define IDX_PORT_MONO   16'h03B4
`define DATA_PORT_MONO  16'h03B5
`define IDX_PORT_COLOR  16'h03D4
`define DATA_PORT_COLOR 16'h03D5

// ----------------------------------------------------------------------
// Indexed register numbers.
// ----------------------------------------------------------------------
`define IDX_HTOTAL      6'h00
`define IDX_HDISP_END   6'h01
`define IDX_HBLANK_ST   6'h02
`define IDX_HBLANK_END  6'h03
`define IDX_HSYNC_ST    6'h04
`define IDX_HSYNC_END   6'h05
`define IDX_HOVERFLOW   6'h3F
`define IDX_PROT_LAST   6'h05
`define IDX_KEY_FREE_HI 6'h18
`define IDX_KEY_EXEMPT0 6'h33
`define IDX_KEY_EXEMPT1 6'h35

// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define SEL_MSB         5
`define SKEW_MSB        6
`define SKEW_LSB        5
`define END_MSB         4
`define HBE_TOP_BIT     7
`define OVF_HTOTAL_BIT  0
`define OVF_HBLANK_BIT  2
`define OVF_HSYNC_BIT   4

// ----------------------------------------------------------------------
// Reset values and timing counts.
// ----------------------------------------------------------------------
`define REG_RESET       8'h00
`define SEL_RESET       6'h00
`define HTOTAL_ADD_VGA  10'h004
`define HTOTAL_ADD_EGA  10'h001
`define DOTS_LAST_8     4'h7
`define DOTS_LAST_9     4'h8
`define HCOUNT_TOP      9'h1FF

`endif

// ==== crt_horizontal_timing_regs.v ====
// Summary of operation
// - Index port holds six-bit selector choosing data-port register; bits 7:6 reserved.
// - Ports decode at 3B4/3B5 mono or 3D4/3D5 colour, per emulation bit.
// - Line length is horizontal total plus 5 (VGA) or plus 2 (EGA), capped at 512 characters.
// - Character width is 8 or 9 pixel clocks, chosen by sequencer bit.
// - Display enable ends after counter equals display end; shows value plus one.
// - Blanking starts when the counter equals the blank start value.
// - Blank-end bits 6:5 skew display enable by zero to three characters.
// - EGA blanking ends at first five-bit match after blanking starts.
// - Horizontal sync starts when counter equals the sync start value.
// - Sync-end bits 6:5 skew the sync output by zero to three characters.
// - Sync ends at first five-bit match with counter after sync starts.
// - While protection is active, writes to indices 0 to 5 are ignored.
// - Writes above index 18, except 33 and 35, need the unlock key.
// - Total, blank start and sync start gain bit 8 from overflow register.
`timescale 1ns/100ps
`include "crt_htiming_defs.vh"

module crt_horizontal_timing_regs (
  input  wire       clock_i,
  input  wire       srst_i,
  input  wire [15:0] io_addr_i,
  input  wire       io_wr_i,
  input  wire       io_rd_i,
  input  wire [7:0] io_wdata_i,
  output reg  [7:0] io_rdata_o,
  output reg        io_rack_o,
  input  wire       color_emul_i,
  input  wire       vga_mode_i,
  input  wire       char_8dot_i,
  input  wire       wr_protect_i,
  input  wire       ext_key_i,
  output wire       char_tick_o,
  output reg  [8:0] hcount_o,
  output reg        line_end_o,
  output reg        hdisp_en_o,
  output reg        hblank_o,
  output reg        hsync_o
);

  // --------------------------------------------------------------------
  // Register storage.
  // --------------------------------------------------------------------
  reg [5:0] sel_r;
  reg [7:0] htotal_r;
  reg [7:0] hdisp_end_r;
  reg [7:0] hblank_st_r;
  reg [7:0] hblank_end_r;
  reg [7:0] hsync_st_r;
  reg [7:0] hsync_end_r;
  reg [7:0] hoverflow_r;

  // --------------------------------------------------------------------
  // Port decode.
  // --------------------------------------------------------------------
  wire [15:0] idx_port;
  wire [15:0] data_port;
  wire        idx_hit;
  wire        data_hit;
  wire        is_prot;
  wire        needs_key;
  wire        wr_ok;
  wire        data_wr;

  assign idx_port  = color_emul_i ? `IDX_PORT_COLOR : `IDX_PORT_MONO;
  assign data_port = color_emul_i ? `DATA_PORT_COLOR : `DATA_PORT_MONO;
  assign idx_hit   = (io_addr_i == idx_port);
  assign data_hit  = (io_addr_i == data_port);

  assign is_prot   = (sel_r <= `IDX_PROT_LAST);
  assign needs_key = (sel_r > `IDX_KEY_FREE_HI) && (sel_r != `IDX_KEY_EXEMPT0) &&
                     (sel_r != `IDX_KEY_EXEMPT1);
  assign wr_ok     = !(is_prot && wr_protect_i) && !(needs_key && !ext_key_i);
  assign data_wr   = io_wr_i && data_hit && wr_ok;

  // --------------------------------------------------------------------
  // Register writes.
  // --------------------------------------------------------------------
  always @(posedge clock_i) begin
    if (srst_i) begin
      sel_r        <= `SEL_RESET;
      htotal_r     <= `REG_RESET;
      hdisp_end_r  <= `REG_RESET;
      hblank_st_r  <= `REG_RESET;
      hblank_end_r <= `REG_RESET;
      hsync_st_r   <= `REG_RESET;
      hsync_end_r  <= `REG_RESET;
      hoverflow_r  <= `REG_RESET;
    end else begin
      if (io_wr_i && idx_hit) begin
        sel_r <= io_wdata_i[`SEL_MSB:0];
      end
      if (data_wr) begin
        case (sel_r)
          `IDX_HTOTAL:     htotal_r     <= io_wdata_i;
          `IDX_HDISP_END:  hdisp_end_r  <= io_wdata_i;
          `IDX_HBLANK_ST:  hblank_st_r  <= io_wdata_i;
          `IDX_HBLANK_END: hblank_end_r <= io_wdata_i;
          `IDX_HSYNC_ST:   hsync_st_r   <= io_wdata_i;
          `IDX_HSYNC_END:  hsync_end_r  <= io_wdata_i;
          `IDX_HOVERFLOW:  hoverflow_r  <= io_wdata_i;
          default: begin
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Register reads.
  // --------------------------------------------------------------------
  reg [7:0] rd_mux;

  always @* begin
    rd_mux = 8'h00;
    if (idx_hit) begin
      rd_mux = {2'b00, sel_r};
    end else if (data_hit) begin
      case (sel_r)
        `IDX_HTOTAL:     rd_mux = htotal_r;
        `IDX_HDISP_END:  rd_mux = hdisp_end_r;
        `IDX_HBLANK_ST:  rd_mux = hblank_st_r;
        `IDX_HBLANK_END: rd_mux = hblank_end_r;
        `IDX_HSYNC_ST:   rd_mux = hsync_st_r;
        `IDX_HSYNC_END:  rd_mux = hsync_end_r;
        `IDX_HOVERFLOW:  rd_mux = hoverflow_r;
        default:         rd_mux = 8'h00;
      endcase
    end
  end

  always @(posedge clock_i) begin
    if (srst_i) begin
      io_rdata_o <= 8'h00;
      io_rack_o  <= 1'b0;
    end else begin
      io_rack_o <= io_rd_i && (idx_hit || data_hit);
      if (io_rd_i) begin
        io_rdata_o <= rd_mux;
      end
    end
  end

  // --------------------------------------------------------------------
  // Character clock.
  // --------------------------------------------------------------------
  reg  [3:0] dot_r;
  wire [3:0] dot_last;
  wire       tick;

  assign dot_last    = char_8dot_i ? `DOTS_LAST_8 : `DOTS_LAST_9;
  assign tick        = (dot_r >= dot_last);
  assign char_tick_o = tick;

  always @(posedge clock_i) begin
    if (srst_i) begin
      dot_r <= 4'h0;
    end else if (tick) begin
      dot_r <= 4'h0;
    end else begin
      dot_r <= dot_r + 4'h1;
    end
  end

  // --------------------------------------------------------------------
  // Horizontal character counter.
  // --------------------------------------------------------------------
  wire [8:0] total9;
  wire [8:0] bstart9;
  wire [8:0] sstart9;
  wire [9:0] last_cnt;
  wire       at_end;
  wire       at_top;
  wire       wrap;
  reg  [8:0] hcount_nxt;
  reg        line_end_nxt;

  assign total9   = {hoverflow_r[`OVF_HTOTAL_BIT], htotal_r};
  assign bstart9  = {hoverflow_r[`OVF_HBLANK_BIT], hblank_st_r};
  assign sstart9  = {hoverflow_r[`OVF_HSYNC_BIT], hsync_st_r};
  assign last_cnt = {1'b0, total9} + (vga_mode_i ? `HTOTAL_ADD_VGA : `HTOTAL_ADD_EGA);
  assign at_end   = ({1'b0, hcount_o} >= last_cnt);
  assign at_top   = (hcount_o == `HCOUNT_TOP);
  assign wrap     = at_end || at_top;

  always @* begin
    hcount_nxt   = hcount_o;
    line_end_nxt = 1'b0;
    if (tick) begin
      line_end_nxt = wrap;
      if (wrap) begin
        hcount_nxt = 9'h000;
      end else begin
        hcount_nxt = hcount_o + 9'h001;
      end
    end
  end

  // --------------------------------------------------------------------
  // Counter registers.
  // --------------------------------------------------------------------
  // counter state update
  always @(posedge clock_i) begin
    if (srst_i) begin
      hcount_o   <= 9'h000;
      line_end_o <= 1'b0;
    end else begin
      hcount_o   <= hcount_nxt;
      line_end_o <= line_end_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Raw display enable, blanking and sync.
  // --------------------------------------------------------------------
  reg        de_raw_r;
  reg        sync_raw_r;
  wire [5:0] hbe6;
  wire       blank_match;
  wire       sync_match;

  assign hbe6 = {hsync_end_r[`HBE_TOP_BIT], hblank_end_r[`END_MSB:0]};
  assign blank_match = vga_mode_i ? (hcount_o[5:0] == hbe6) :
                       (hcount_o[4:0] == hblank_end_r[`END_MSB:0]);
  assign sync_match  = (hcount_o[4:0] == hsync_end_r[`END_MSB:0]);

  always @(posedge clock_i) begin
    if (srst_i) begin
      de_raw_r   <= 1'b0;
      hblank_o   <= 1'b0;
      sync_raw_r <= 1'b0;
    end else if (tick) begin
      if (wrap) begin
        de_raw_r <= 1'b1;
      end else if (hcount_o == {1'b0, hdisp_end_r}) begin
        de_raw_r <= 1'b0;
      end
      if (hblank_o) begin
        if (blank_match) begin
          hblank_o <= 1'b0;
        end
      end else if (hcount_o == bstart9) begin
        hblank_o <= 1'b1;
      end
      if (sync_raw_r) begin
        if (sync_match) begin
          sync_raw_r <= 1'b0;
        end
      end else if (hcount_o == sstart9) begin
        sync_raw_r <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Skew delay lines.
  // --------------------------------------------------------------------
  reg [3:0] de_pipe_r;
  reg [3:0] sync_pipe_r;

  always @(posedge clock_i) begin
    if (srst_i) begin
      de_pipe_r   <= 4'h0;
      sync_pipe_r <= 4'h0;
      hdisp_en_o  <= 1'b0;
      hsync_o     <= 1'b0;
    end else begin
      if (tick) begin
        de_pipe_r   <= {de_pipe_r[2:0], de_raw_r};
        sync_pipe_r <= {sync_pipe_r[2:0], sync_raw_r};
      end
      hdisp_en_o <= de_pipe_r[hblank_end_r[`SKEW_MSB:`SKEW_LSB]];
      hsync_o    <= sync_pipe_r[hsync_end_r[`SKEW_MSB:`SKEW_LSB]];
    end
  end

endmodule // crt_horizontal_timing_regs

// ==== crt_htiming_checker.sv ====
`timescale 1ns/100ps
module crt_htiming_checker (
  input wire        clock_i,
  input wire        srst_i,
  input wire [15:0] io_addr_i,
  input wire        io_rd_i,
  input wire        io_wr_i,
  input wire        color_emul_i,
  input wire        io_rack_o,
  input wire        char_tick_o,
  input wire [8:0]  hcount_o,
  input wire        line_end_o,
  input wire        hdisp_en_o,
  input wire        hblank_o,
  input wire        hsync_o
);
  wire hit = io_rd_i && io_addr_i[15:1] == (color_emul_i ? 15'h01ea : 15'h01da);
  default clocking @(posedge clock_i); endclocking
  default disable iff (srst_i);
  AST_READ_ANSWER: assert property (hit |=> io_rack_o)
    else $error("port read not answered");
  AST_READ_STRAY: assert property (!hit |=> !io_rack_o)
    else $error("stray read answer");
  AST_CHAR_MIN: assert property (char_tick_o |=> !char_tick_o [*7])
    else $error("character too short");
  AST_CHAR_MAX: assert property (char_tick_o |-> ##[8:9] char_tick_o)
    else $error("character too long");
  AST_COUNT_HOLD: assert property (!char_tick_o |=> $stable(hcount_o))
    else $error("counter moved off tick");
  AST_COUNT_STEP: assert property (char_tick_o |=>
    hcount_o == $past(hcount_o) + 9'h001 || hcount_o == 9'h000)
    else $error("counter step wrong");
  AST_LINE_MARK: assert property (
    char_tick_o ##1 hcount_o == 9'h000 |-> ##[0:1] line_end_o)
    else $error("line end missing");
  AST_BLANK_EDGE: assert property (
    !$past(srst_i) && $changed(hblank_o) |-> $past(char_tick_o))
    else $error("blank moved off tick");
  AST_SYNC_EDGE: assert property (
    !$past(srst_i) && !$past(io_wr_i, 2) && $changed(hsync_o) |-> $past(char_tick_o, 2))
    else $error("sync moved off tick");
  AST_DISP_EDGE: assert property (
    !$past(srst_i) && !$past(io_wr_i, 2) && $changed(hdisp_en_o) |-> $past(char_tick_o, 2))
    else $error("enable moved off tick");
endmodule // crt_htiming_checker

bind crt_horizontal_timing_regs crt_htiming_checker crt_htiming_checker_inst (
  .clock_i, .srst_i, .io_addr_i, .io_rd_i, .io_wr_i, .color_emul_i, .io_rack_o, .char_tick_o,
  .hcount_o, .line_end_o, .hdisp_en_o, .hblank_o, .hsync_o
);

// ==== host_bus.sv ====
`timescale 1ns/100ps
module host_bus (
  input  wire        clock_i,
  input  wire        rack_i,
  input  wire [7:0]  rdata_i,
  output reg  [15:0] addr_o = 16'hffff,
  output reg         wr_o = 1'b0,
  output reg         rd_o = 1'b0,
  output reg  [7:0]  wdata_o = 8'h00
);
  task automatic put(input [15:0] a, input [7:0] d);
    begin
      @(posedge clock_i) #1;
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(posedge clock_i) #1;
      wr_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
    end
  endtask
  task automatic get(input [15:0] a, output [8:0] r);
    begin
      @(posedge clock_i) #1;
      addr_o = a;
      rd_o = 1'b1;
      @(posedge clock_i) #1;
      rd_o = 1'b0;
      addr_o = ~a;
      @(posedge clock_i);
      r = {rack_i, rdata_i};
    end
  endtask
  task automatic reg_wr(input [15:0] b, input [5:0] i, input [7:0] d);
    begin
      put(b, {2'b00, i});
      put(b + 16'h0001, d);
    end
  endtask
  task automatic reg_rd(input [15:0] b, input [5:0] i, output [8:0] r);
    begin
      put(b, {2'b00, i});
      get(b + 16'h0001, r);
    end
  endtask
endmodule // host_bus

// ==== test_crt_horizontal_timing_regs.sv ====
`timescale 1ns/100ps
module test_crt_horizontal_timing_regs;
  reg         clock_i = 1'b0;
  reg         srst_i = 1'b1;
  reg         color_emul_i = 1'b1;
  reg         vga_mode_i = 1'b1;
  reg         char_8dot_i = 1'b1;
  reg         wr_protect_i = 1'b0;
  reg         ext_key_i = 1'b0;
  wire [15:0] io_addr_i;
  wire [7:0]  io_wdata_i, io_rdata_o;
  wire [8:0]  hcount_o;
  wire        io_wr_i, io_rd_i, io_rack_o, char_tick_o, line_end_o, hdisp_en_o, hblank_o, hsync_o;
  reg  [8:0]  r;
  reg  [2:0]  pv = 3'b000;
  integer     failures = 0, cmp_count = 0, cyc = 0, t_le = 0, per = 0, t_bl = 0, t_sy = 0;
  integer     t_de = 0, nb = 0, ns = 0, nd = 0, lb = 0, ls = 0, ld = 0, hc_bl = 0, k, e0, e1;
  crt_horizontal_timing_regs crt_horizontal_timing_regs_inst (
    .clock_i, .srst_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i, .io_rdata_o, .io_rack_o,
    .color_emul_i, .vga_mode_i, .char_8dot_i, .wr_protect_i, .ext_key_i, .char_tick_o,
    .hcount_o, .line_end_o, .hdisp_en_o, .hblank_o, .hsync_o
  );
  host_bus host_bus_inst (
    .clock_i, .rack_i(io_rack_o), .rdata_i(io_rdata_o), .addr_o(io_addr_i), .wr_o(io_wr_i),
    .rd_o(io_rd_i), .wdata_o(io_wdata_i)
  );
  initial begin
    forever #10 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    pv <= {hblank_o, hsync_o, hdisp_en_o};
    if (hblank_o && !pv[2]) begin
      t_bl <= cyc;
      hc_bl <= hcount_o;
    end
    if (hsync_o && !pv[1]) t_sy <= cyc;
    if (hdisp_en_o && !pv[0]) t_de <= cyc;
    if (char_tick_o) {nb, ns, nd} <= {nb + hblank_o, ns + hsync_o, nd + hdisp_en_o};
    if (line_end_o) begin
      per <= cyc - t_le;
      t_le <= cyc;
      {lb, ls, ld} <= {nb, ns, nd};
      {nb, ns, nd} <= 96'h0;
    end
    if (cyc == 50000) begin
      failures = failures + 1;
      $display("ERROR %0t: timeout", $time);
      finish_test;
    end
  end
  task chk(input [31:0] s, input [31:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (s !== e) begin
        failures = failures + 1;
        $display("ERROR %0t: saw %0h expected %0h", $time, s, e);
      end
    end
  endtask
  task w(input [5:0] i, input [7:0] d);
    host_bus_inst.reg_wr(16'h03d4, i, d);
  endtask
  task rr(input [5:0] i, input [31:0] e);
    begin
      host_bus_inst.reg_rd(16'h03d4, i, r);
      chk(r, e);
    end
  endtask
  task lines(input integer n);
    repeat (n) @(posedge line_end_o);
  endtask
  task t_access;
    integer i;
    begin
      for (i = 0; i < 6; i = i + 1) w(i[5:0], 8'ha0 + i[7:0]);
      for (i = 0; i < 6; i = i + 1) rr(i[5:0], 32'h01a0 + i);
      host_bus_inst.put(16'h03d4, 8'hc5);
      host_bus_inst.get(16'h03d4, r);
      chk(r, 32'h0105);
      rr(6'h10, 32'h0100);
      #1 color_emul_i = 1'b0;
      host_bus_inst.get(16'h03d5, r);
      chk(r[8], 32'h0);
      host_bus_inst.put(16'h03d5, 8'h00);
      host_bus_inst.reg_rd(16'h03b4, 6'h05, r);
      chk(r, 32'h01a5);
      #1 color_emul_i = 1'b1;
      $display("access test done");
    end
  endtask
  task t_protect;
    begin
      wr_protect_i = 1'b1;
      w(6'h02, 8'h11);
      rr(6'h02, 32'h01a2);
      #1 wr_protect_i = 1'b0;
      w(6'h3f, 8'h15);
      rr(6'h3f, 32'h0100);
      #1 ext_key_i = 1'b1;
      w(6'h3f, 8'h15);
      rr(6'h3f, 32'h0115);
      w(6'h3f, 8'h00);
      w(6'h02, 8'h11);
      rr(6'h02, 32'h0111);
      $display("protect test done");
    end
  endtask
  task t_shape;
    begin
      w(6'h00, 8'h3c);
      w(6'h01, 8'h13);
      w(6'h02, 8'h28);
      w(6'h03, 8'h84);
      w(6'h04, 8'h2d);
      w(6'h05, 8'h8a);
      lines(3);
      chk(ld, 32'h0014);
      chk(lb, 32'h003d);
      chk(ls, 32'h001e);
      chk(hc_bl, 32'h0029);
      #1 vga_mode_i = 1'b0;
      lines(3);
      chk(lb, 32'h001a);
      chk(ls, 32'h001b);
      #1 vga_mode_i = 1'b1;
      $display("shape test done");
    end
  endtask
  task t_skew;
    begin
      w(6'h04, 8'h28);
      for (k = 0; k < 4; k = k + 1) begin
        w(6'h03, 8'h84 | {1'b0, k[1:0], 5'h00});
        w(6'h05, 8'h8a | {1'b0, k[1:0], 5'h00});
        lines(3);
        repeat (40) @(posedge clock_i);
        if (k == 0) {e0, e1} = {t_de - t_le, t_sy - t_bl};
        chk(t_de - t_le, e0 + 8 * k);
        chk(t_sy - t_bl, e1 + 8 * k);
      end
      $display("skew test done");
    end
  endtask
  task t_line;
    begin
      lines(3);
      chk(per, 32'h0208);
      #1 {vga_mode_i, char_8dot_i} = 2'b00;
      lines(3);
      chk(per, 32'h022e);
      w(6'h3f, 8'h05);
      lines(3);
      chk(per, 32'h0b2e);
      chk(hc_bl, 32'h0129);
      $display("line test done");
    end
  endtask
  task finish_test;
    begin
      $display("compares %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(posedge clock_i);
    #1 srst_i = 1'b0;
    t_access;
    t_protect;
    t_shape;
    t_skew;
    t_line;
    finish_test;
  end
endmodule // test_crt_horizontal_timing_regs
